/* ipr_map.svh */
// Register offsets, reset values and widths for interrupt pin routing
`ifndef IPR_MAP_SVH
`define IPR_MAP_SVH

// ************************************************************
// Register byte offsets
// ************************************************************
`define IPR_OFS_CTL 8'h00
`define IPR_OFS_GDIR 8'h04
`define IPR_OFS_GOUT 8'h08
`define IPR_OFS_STAT 8'h0c

// ************************************************************
// Widths and reset values
// ************************************************************
`define IPR_CTL_W 12
`define IPR_GPIO_W 4
`define IPR_CTL_RST 12'h000
`define IPR_GPIO_RST 4'h0
`define IPR_ROUTE_INTA 4'h0
`define IPR_PWR_D0 2'h0

// ************************************************************
// Pin numbers with a special role
// ************************************************************
`define IPR_PIN_FIRST 4'h3
`define IPR_PIN_SIRQ 4'h9
`define IPR_PIN_ALED 4'ha
`define IPR_PIN_CLED 4'hc
`define IPR_PIN_SDA 4'he
`define IPR_PIN_ZV 4'hf

`endif

/* ipr_pkg.sv */
// Types for interrupt pin routing
package ipr_pkg;

	// ************************************************************
	// Control register layout, msb first
	// ************************************************************
	typedef struct packed {
		logic zv_en; // Zoomed video enable on IRQ15
		logic [1:0] pwr_state; // Power state, 0 is D0
		logic pm_event_enable; // Event enable
		logic ri_en; // Ring forward enable
		logic srom_en; // Serial ROM owns IRQ12/14
		logic sirq_en; // Serialized IRQ mode
		logic led_en; // Card LED on IRQ12
		logic [3:0] route; // ISA IRQ number, 0 means INTA
	} ipr_ctl_t;

	// Role of one IRQ pin
	typedef enum logic [3:0] {
		IPR_NONE,
		IPR_IRQ,
		IPR_TRI,
		IPR_CLED,
		IPR_SIRQ,
		IPR_ALED,
		IPR_GPIO,
		IPR_SCL,
		IPR_SDA,
		IPR_ZV
	} ipr_role_t;

	// Output and enable view of the sixteen IRQ pins
	typedef struct packed {
		logic [15:0] o;
		logic [15:0] oe;
	} ipr_pins_t;

	// Whole module state
	typedef struct packed {
		ipr_ctl_t ctl;
		logic [3:0] gdir;
		logic [3:0] gout;
		logic [31:0] rdata;
		logic [15:0] pin_s1;
		logic [15:0] pin_s2;
		logic ring_s1;
		logic ring_s2;
		logic led_s1;
		logic led_s2;
		ipr_pins_t pins;
		logic inta_oe;
		logic ri_pme_n;
	} ipr_state_t;

endpackage : ipr_pkg

/* ipr_route.sv */
// Interrupt pin routing: socket interrupt to INTA/ISA IRQ, pin role muxing
`include "ipr_map.svh"
`timescale 1ns/1ps
`default_nettype none

module ipr_route (
	input wire logic clk,
	input wire logic rstn,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Socket side, same clock
	input wire logic card_irq_req,
	input wire logic card16_present,
	input wire logic pme_event,
	input wire logic activity,
	input wire logic sirq_drive_low,
	input wire logic scl_drive_low,
	input wire logic sda_drive_low,
	input wire logic zoomed_video_enable,
	// Card pins, asynchronous
	input wire logic card_ring_input,
	input wire logic card_led_input,
	// IRQ pins as three signals
	input wire logic [15:0] irq_i,
	output logic [15:0] irq_o,
	output logic [15:0] irq_oe,
	// Synchronised pin levels for serial engines
	output logic sirq_line_in,
	output logic sda_line_in,
	// Open-drain INTA, output always low
	output logic inta_o,
	output logic inta_oe,
	// Shared ring forward / event pin, active low
	output logic ring_forward_output_n
);

	// ************************************************************
	// Pin role decode
	// ************************************************************

	// Role of pin n under control c; used for drive and status
	function automatic ipr_pkg::ipr_role_t pin_role(
		input logic [3:0] n,
		input ipr_pkg::ipr_ctl_t c
	);
		ipr_pkg::ipr_role_t r;
		r = ipr_pkg::IPR_IRQ;
		if (n < `IPR_PIN_FIRST) begin
			r = ipr_pkg::IPR_NONE; // No IRQ0-2 pins exist
		end else if (c.sirq_en && (n == 4'h3 || n == 4'h4 ||
			n == 4'h5 || n == 4'h7)) begin
			r = ipr_pkg::IPR_GPIO;
		end else if (c.sirq_en && n == `IPR_PIN_SIRQ) begin
			r = ipr_pkg::IPR_SIRQ;
		end else if (c.sirq_en && n == `IPR_PIN_ALED) begin
			r = ipr_pkg::IPR_ALED;
		end else if (c.srom_en && n == `IPR_PIN_CLED) begin
			r = ipr_pkg::IPR_SCL;
		end else if (c.srom_en && n == `IPR_PIN_SDA) begin
			r = ipr_pkg::IPR_SDA;
		end else if (c.led_en && n == `IPR_PIN_CLED) begin
			r = ipr_pkg::IPR_CLED;
		end else if (c.zv_en && n == `IPR_PIN_ZV) begin
			r = ipr_pkg::IPR_ZV;
		end else if (n <= `IPR_PIN_SIRQ || n == `IPR_PIN_CLED ||
			n == `IPR_PIN_SDA) begin
			r = ipr_pkg::IPR_TRI;
		end
		return r;
	endfunction : pin_role

	// GPIO bit that pin n carries; only meaningful for GPIO pins
	function automatic logic [1:0] gpio_bit(input logic [3:0] n);
		logic [1:0] b;
		b = 2'h3; // IRQ7
		case (n)
			4'h3: begin
				b = 2'h0;
			end
			4'h4: begin
				b = 2'h1;
			end
			4'h5: begin
				b = 2'h2;
			end
			default: begin
				b = 2'h3;
			end
		endcase
		return b;
	endfunction : gpio_bit

	// ************************************************************
	// State
	// ************************************************************
	ipr_pkg::ipr_state_t st_r; // Registered state
	ipr_pkg::ipr_state_t st_nxt; // Next state
	logic card_on_isa; // Card interrupt routed to an ISA pin
	logic pme_role; // Shared pin carries the event

	// Routing decision from the route field
	assign card_on_isa = (st_r.ctl.route >= `IPR_PIN_FIRST);
	assign pme_role = st_r.ctl.pm_event_enable ||
		(st_r.ctl.pwr_state != `IPR_PWR_D0);

	// ************************************************************
	// Next-state logic
	// ************************************************************

	// Registers, synchronisers and pin drive in one pass
	always_comb begin
		ipr_pkg::ipr_role_t role;
		logic [3:0] gpio_in;
		st_nxt = st_r;
		role = ipr_pkg::IPR_NONE;
		gpio_in = {st_r.pin_s2[7], st_r.pin_s2[5],
			st_r.pin_s2[4], st_r.pin_s2[3]};

		// Two-flop synchronisers; first stage feeds second only
		st_nxt.pin_s1 = irq_i;
		st_nxt.pin_s2 = st_r.pin_s1;
		st_nxt.ring_s1 = card_ring_input;
		st_nxt.ring_s2 = st_r.ring_s1;
		st_nxt.led_s1 = card_led_input;
		st_nxt.led_s2 = st_r.led_s1;

		// Register writes; unmapped offsets are ignored
		if (reg_wr) begin
			case (reg_addr)
				`IPR_OFS_CTL: begin
					st_nxt.ctl = reg_wdata[`IPR_CTL_W-1:0];
				end
				`IPR_OFS_GDIR: begin
					st_nxt.gdir = reg_wdata[`IPR_GPIO_W-1:0];
				end
				`IPR_OFS_GOUT: begin
					st_nxt.gout = reg_wdata[`IPR_GPIO_W-1:0];
				end
				default: begin
				end
			endcase
		end

		// Read data stands only in the cycle after the strobe
		st_nxt.rdata = 32'h0000_0000;
		if (reg_rd) begin
			case (reg_addr)
				`IPR_OFS_CTL: begin
					st_nxt.rdata = {20'h0_0000, st_r.ctl};
				end
				`IPR_OFS_GDIR: begin
					st_nxt.rdata = {28'h000_0000, st_r.gdir};
				end
				`IPR_OFS_GOUT: begin
					st_nxt.rdata = {28'h000_0000, st_r.gout};
				end
				`IPR_OFS_STAT: begin
					st_nxt.rdata = {23'h00_0000,
						pin_role(`IPR_PIN_CLED, st_r.ctl) ==
							ipr_pkg::IPR_SCL,
						st_r.pin_s2[`IPR_PIN_SDA],
						pme_role, st_r.ring_s2,
						card_irq_req, gpio_in};
				end
				default: begin
					st_nxt.rdata = 32'h0000_0000;
				end
			endcase
		end

		// Pin drive; IRQs and the card LED are active high, the activity LED and serial lines low
		for (int i = 0; i < 16; i++) begin
			role = pin_role(4'(i), st_r.ctl);
			case (role)
				ipr_pkg::IPR_IRQ: begin
					// Totem-pole IRQ pins always drive
					st_nxt.pins.o[i] = card_irq_req &&
						(st_r.ctl.route == 4'(i));
					st_nxt.pins.oe[i] = 1'b1;
				end
				ipr_pkg::IPR_TRI: begin
					// Released to high impedance unless selected and requested
					st_nxt.pins.o[i] = card_irq_req;
					st_nxt.pins.oe[i] = card_irq_req &&
						(st_r.ctl.route == 4'(i));
				end
				ipr_pkg::IPR_CLED: begin
					st_nxt.pins.o[i] = st_r.led_s2;
					st_nxt.pins.oe[i] = 1'b1;
				end
				ipr_pkg::IPR_SIRQ: begin
					// Shared serial line: drive low only
					st_nxt.pins.o[i] = 1'b0;
					st_nxt.pins.oe[i] = sirq_drive_low;
				end
				ipr_pkg::IPR_ALED: begin
					st_nxt.pins.o[i] = ~activity;
					st_nxt.pins.oe[i] = 1'b1;
				end
				ipr_pkg::IPR_GPIO: begin
					// Pure software path, no tie to bus logic
					st_nxt.pins.o[i] =
						st_r.gout[gpio_bit(4'(i))];
					st_nxt.pins.oe[i] =
						st_r.gdir[gpio_bit(4'(i))];
				end
				ipr_pkg::IPR_SCL: begin
					st_nxt.pins.o[i] = 1'b0;
					st_nxt.pins.oe[i] = scl_drive_low;
				end
				ipr_pkg::IPR_SDA: begin
					st_nxt.pins.o[i] = 1'b0;
					st_nxt.pins.oe[i] = sda_drive_low;
				end
				ipr_pkg::IPR_ZV: begin
					st_nxt.pins.o[i] = ~zoomed_video_enable;
					st_nxt.pins.oe[i] = 1'b1;
				end
				default: begin
					// IRQ0-2 do not exist
					st_nxt.pins.o[i] = 1'b0;
					st_nxt.pins.oe[i] = 1'b0;
				end
			endcase
		end

		// INTA is open drain, asserted while requested and routed there
		st_nxt.inta_oe = card_irq_req &&
			(st_r.ctl.route == `IPR_ROUTE_INTA);
		if (!card_on_isa && st_r.ctl.route != `IPR_ROUTE_INTA) begin
			st_nxt.inta_oe = 1'b0; // Route 1-2 is parked
		end

		// Shared pin: event role beats ring forwarding
		if (pme_role) begin
			st_nxt.ri_pme_n = ~pme_event;
		end else if (st_r.ctl.ri_en && card16_present) begin
			st_nxt.ri_pme_n = st_r.ring_s2;
		end else begin
			st_nxt.ri_pme_n = 1'b1; // Idle high
		end
	end

	// ************************************************************
	// State register
	// ************************************************************

	// Synchronous active-low reset to constants
	always_ff @(posedge clk) begin
		if (!rstn) begin
			st_r.ctl <= `IPR_CTL_RST;
			st_r.gdir <= `IPR_GPIO_RST;
			st_r.gout <= `IPR_GPIO_RST;
			st_r.rdata <= 32'h0000_0000;
			st_r.pin_s1 <= 16'h0000;
			st_r.pin_s2 <= 16'h0000;
			st_r.ring_s1 <= 1'b1;
			st_r.ring_s2 <= 1'b1;
			st_r.led_s1 <= 1'b0;
			st_r.led_s2 <= 1'b0;
			st_r.pins <= '0;
			st_r.inta_oe <= 1'b0;
			st_r.ri_pme_n <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ************************************************************
	// Outputs, all from flip-flops except the constant inta_o
	// ************************************************************
	assign reg_rdata = st_r.rdata;
	assign irq_o = st_r.pins.o;
	assign irq_oe = st_r.pins.oe;
	assign sirq_line_in = st_r.pin_s2[`IPR_PIN_SIRQ];
	assign sda_line_in = st_r.pin_s2[`IPR_PIN_SDA];
	assign inta_o = 1'b0;
	assign inta_oe = st_r.inta_oe;
	assign ring_forward_output_n = st_r.ri_pme_n;

endmodule : ipr_route

`default_nettype wire

/* ipr_route_monitor.sv */
// Checker for interrupt pin routing, bound to ipr_route
`include "ipr_map.svh"
`timescale 1ns/1ps
`default_nettype none

module ipr_route_monitor (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic card_irq_req,
	input wire logic card16_present,
	input wire logic pme_event,
	input wire logic activity,
	input wire logic sirq_drive_low,
	input wire logic scl_drive_low,
	input wire logic sda_drive_low,
	input wire logic card_ring_input,
	input wire logic card_led_input,
	input wire logic [15:0] irq_o,
	input wire logic [15:0] irq_oe,
	input wire logic inta_o,
	input wire logic inta_oe,
	input wire logic ring_forward_output_n
);
	// ****
	// Shadow of software state
	// ****
	ipr_pkg::ipr_ctl_t c_r; // Control copy
	logic [3:0] gd_r; // Direction copy
	logic [3:0] go_r; // Output copy
	logic up1_r; // First stage of the settle delay
	logic up_r; // High once two edges have passed since release

	// Follow writes; gap after reset hides pre-reset history
	always_ff @(posedge clk) begin
		// Two stages, so the first edge after release, whose outputs are still reset values, is skipped
		up1_r <= rstn;
		up_r <= up1_r;
		if (!rstn) begin
			c_r <= '0;
			gd_r <= 4'h0;
			go_r <= 4'h0;
		end else if (reg_wr) begin
			if (reg_addr == `IPR_OFS_CTL) c_r <= reg_wdata[11:0];
			if (reg_addr == `IPR_OFS_GDIR) gd_r <= reg_wdata[3:0];
			if (reg_addr == `IPR_OFS_GOUT) go_r <= reg_wdata[3:0];
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!rstn || !up_r);

	// ****
	// Pin role checks
	// ****
	a_inta_follow: assert property (inta_oe == $past(c_r.route == 4'h0 && card_irq_req) && !inta_o)
		else $error("INTA drive wrong");
	a_isa_tri: assert property ($past(c_r.route == 4'h5 && !c_r.sirq_en) |->
		irq_oe[5] == $past(card_irq_req)) else $error("IRQ5 drive wrong");
	a_isa_driven: assert property ($past(c_r.route == 4'hb) |-> irq_oe[11] &&
		irq_o[11] == $past(card_irq_req)) else $error("IRQ11 drive wrong");
	a_cled_pin: assert property ($past(c_r.led_en && !c_r.srom_en) |-> irq_oe[12] &&
		irq_o[12] == $past(card_led_input, 3)) else $error("Card LED wrong");
	a_sirq_pins: assert property ($past(c_r.sirq_en) |-> irq_oe[9] == $past(sirq_drive_low)
		&& !irq_o[9] && irq_oe[10] && irq_o[10] == !$past(activity)) else $error("Serial IRQ pins");
	a_gpio_out: assert property ($past(c_r.sirq_en && gd_r[0]) |-> irq_oe[3] &&
		irq_o[3] == $past(go_r[0])) else $error("GPIO drive wrong");
	a_gpio_in: assert property ($past(c_r.sirq_en && !gd_r[3]) |-> !irq_oe[7])
		else $error("GPIO input driven");
	a_srom_pins: assert property ($past(c_r.srom_en) |-> !irq_o[12] && !irq_o[14] &&
		irq_oe[12] == $past(scl_drive_low) && irq_oe[14] == $past(sda_drive_low))
		else $error("Serial ROM pins");
	a_ring_fwd: assert property ($past(c_r.ri_en && card16_present && !c_r.pm_event_enable &&
		c_r.pwr_state == 2'h0) |-> ring_forward_output_n == $past(card_ring_input, 3))
		else $error("Ring forward wrong");
	a_event_role: assert property ($past(c_r.pm_event_enable || c_r.pwr_state != 2'h0) |->
		ring_forward_output_n == !$past(pme_event)) else $error("Event pin wrong");
	a_plain_idle: assert property ($past(c_r[11:4] == 8'h00 && !card_irq_req) |->
		irq_oe[9:3] == 7'h00 && !irq_oe[12] && !irq_oe[14] && ring_forward_output_n)
		else $error("Idle pins driven");

	// Main scenarios reached
	c_sirq: cover property (c_r.sirq_en && activity);
	c_srom: cover property (c_r.srom_en && scl_drive_low);
	c_event: cover property (c_r.pm_event_enable && pme_event);
endmodule : ipr_route_monitor

bind ipr_route ipr_route_monitor i_ipr_route_monitor (.clk(clk), .rstn(rstn),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .card_irq_req(card_irq_req),
	.card16_present(card16_present), .pme_event(pme_event), .activity(activity),
	.sirq_drive_low(sirq_drive_low), .scl_drive_low(scl_drive_low),
	.sda_drive_low(sda_drive_low), .card_ring_input(card_ring_input),
	.card_led_input(card_led_input), .irq_o(irq_o), .irq_oe(irq_oe), .inta_o(inta_o),
	.inta_oe(inta_oe), .ring_forward_output_n(ring_forward_output_n));
`default_nettype wire

/* ipr_host_model.sv */
// Host side of the ISA IRQ lines, pulled up when nobody drives
`timescale 1ns/1ps
`default_nettype none

module ipr_host_model (
	input wire logic [15:0] irq_o,
	input wire logic [15:0] irq_oe,
	input wire logic [15:0] host_en,
	input wire logic [15:0] host_val,
	output logic [15:0] irq_i
);
	// Device drive wins, else host drive, else pull-up high
	assign irq_i = (irq_oe & irq_o) | (~irq_oe & host_en & host_val) | (~irq_oe & ~host_en);
endmodule : ipr_host_model
`default_nettype wire

/* tb_top.sv */
// Self-checking bench for interrupt pin routing
`include "ipr_map.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fails++; \
	$display("[ERR] t=%0t got %h exp %h", $time, a, b); end end

module tb_top;
	// ****
	// Stimulus and observed signals
	// ****
	logic clk = 1'h0;
	logic rstn = 1'h0;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic wr_s = 1'h0, rd_s = 1'h0, req = 1'h0, c16 = 1'h0, pme = 1'h0, act = 1'h0;
	logic sirq_l = 1'h0, scl_l = 1'h0, ring = 1'h1, led = 1'h0, sda_l = 1'h0, zv = 1'h0;
	logic [15:0] h_en = 16'h0, h_val = 16'h0, irq_i, irq_o, irq_oe;
	logic [31:0] rdata;
	logic inta_o, inta_oe, ring_n, sirq_line, sda_line;
	int fails = 0, n_compared = 0;

	// Clock, 4 ns period
	always #2 clk = ~clk;

	ipr_route i_ipr_route (.clk(clk), .rstn(rstn), .reg_addr(addr), .reg_wdata(wdata),
		.reg_wr(wr_s), .reg_rd(rd_s), .reg_rdata(rdata), .card_irq_req(req),
		.card16_present(c16), .pme_event(pme), .activity(act), .sirq_drive_low(sirq_l),
		.scl_drive_low(scl_l), .sda_drive_low(sda_l), .zoomed_video_enable(zv),
		.card_ring_input(ring), .card_led_input(led), .irq_i(irq_i), .irq_o(irq_o),
		.irq_oe(irq_oe), .sirq_line_in(sirq_line), .sda_line_in(sda_line), .inta_o(inta_o),
		.inta_oe(inta_oe), .ring_forward_output_n(ring_n));
	ipr_host_model i_ipr_host_model (.irq_o(irq_o), .irq_oe(irq_oe), .host_en(h_en),
		.host_val(h_val), .irq_i(irq_i));

	// Let n edges pass, then sample settled outputs
	task w(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : w
	// One-cycle write strobe
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr_s <= 1'h1;
		@(posedge clk);
		wr_s <= 1'h0;
	endtask : wr
	// Read data stands only in the cycle after the strobe
	task rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		addr <= a;
		rd_s <= 1'h1;
		@(posedge clk);
		rd_s <= 1'h0;
		#1;
		`CHK(rdata, e)
	endtask : rd
	// Counts, verdict and end of run
	task final_report;
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : final_report

	// Watchdog, a hang counts as a mismatch
	initial begin
		#100000;
		fails++;
		final_report();
	end

	initial begin
		w(3);
		@(posedge clk) rstn <= 1'h1;
		rd(`IPR_OFS_CTL, 32'h0);
		rd(8'h10, 32'h0);
		`CHK(ring_n, 1'h1)
		@(posedge clk) req <= 1'h1;
		w(2);
		`CHK(inta_oe, 1'h1)
		$display("test reset inta done");
		// Every ISA line, asserted then idle
		for (int r = 3; r < 16; r++) begin
			wr(`IPR_OFS_CTL, r);
			w(2);
			`CHK(irq_o[r], 1'h1)
			`CHK(inta_oe, 1'h0)
			@(posedge clk) req <= 1'h0;
			w(2);
			`CHK(irq_oe[r], r inside {10, 11, 13, 15})
			@(posedge clk) req <= 1'h1;
		end
		$display("test isa done");
		// Route 1 goes nowhere, then the card LED follows its input
		wr(`IPR_OFS_CTL, 32'h1);
		w(2);
		`CHK({inta_oe, irq_oe[9:3]}, 8'h00)
		@(posedge clk) req <= 1'h0;
		wr(`IPR_OFS_CTL, 32'h10);
		for (int v = 0; v < 2; v++) begin
			@(posedge clk) led <= v[0];
			w(4);
			`CHK({irq_oe[12], irq_o[12]}, {1'h1, v[0]})
		end
		// Serial ROM outranks the card LED
		wr(`IPR_OFS_CTL, 32'h50);
		@(posedge clk) scl_l <= 1'h1;
		w(2);
		`CHK({irq_oe[12], irq_o[12], irq_oe[14]}, 3'h4)
		@(posedge clk) sda_l <= 1'h1;
		w(4);
		`CHK({irq_oe[14], irq_o[14], sda_line}, 3'h4)
		rd(`IPR_OFS_STAT, 32'h12f);
		$display("test led rom done");
		wr(`IPR_OFS_CTL, 32'h20);
		wr(`IPR_OFS_GDIR, 32'h3);
		wr(`IPR_OFS_GOUT, 32'h1);
		@(posedge clk);
		act <= 1'h1;
		sirq_l <= 1'h1;
		h_en <= 16'h00a0;
		h_val <= 16'h0080;
		w(4);
		`CHK({irq_oe[10:9], irq_o[10:9]}, 4'hc)
		`CHK({irq_oe[5:3], irq_o[4:3]}, 5'h0d)
		`CHK(sirq_line, 1'h0)
		rd(`IPR_OFS_STAT, 32'h0a9);
		rd(`IPR_OFS_CTL, 32'h20);
		$display("test serial irq done");
		// IRQ15 carries the inverted video enable while its bit is set
		@(posedge clk) zv <= 1'h1;
		wr(`IPR_OFS_CTL, 32'h800);
		w(2);
		`CHK({irq_oe[15], irq_o[15]}, 2'h2)
		@(posedge clk) zv <= 1'h0;
		w(2);
		`CHK({irq_oe[15], irq_o[15]}, 2'h3)
		wr(`IPR_OFS_CTL, 32'h80);
		@(posedge clk);
		c16 <= 1'h1;
		ring <= 1'h0;
		w(4);
		`CHK(ring_n, 1'h0)
		@(posedge clk) c16 <= 1'h0;
		w(2);
		`CHK(ring_n, 1'h1)
		@(posedge clk) c16 <= 1'h1;
		// Event role wins over a pending ring
		wr(`IPR_OFS_CTL, 32'h180);
		w(2);
		`CHK(ring_n, 1'h1)
		@(posedge clk) pme <= 1'h1;
		w(2);
		`CHK(ring_n, 1'h0)
		wr(`IPR_OFS_CTL, 32'h280);
		w(2);
		`CHK(ring_n, 1'h0)
		@(posedge clk) pme <= 1'h0;
		w(2);
		`CHK(ring_n, 1'h1)
		$display("test ring event done");
		// Reset in mid-run with a request pending
		@(posedge clk) begin
			req <= 1'h1;
			rstn <= 1'h0;
		end
		w(3);
		@(posedge clk) rstn <= 1'h1;
		w(2);
		`CHK({inta_oe, ring_n, irq_oe}, 18'h3ac00)
		rd(`IPR_OFS_CTL, 32'h0);
		$display("test mid reset done");
		final_report();
	end
endmodule : tb_top
`default_nettype wire
